// ---- design/dzr_ctrl.sv ----
// controller end: enforces command spacing and captures read bursts
`timescale 1ns/1ps
`default_nettype none
module dzr_ctrl
    import dzr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // user request
    input wire logic reqValid,
    input wire logic [2:0] reqCmd,
    input wire logic [BAW-1:0] reqBank,
    input wire logic [ROWW-1:0] reqAddr,
    output logic reqReady,
    // captured read data
    output logic [DQW-1:0] rdData,
    output logic rdValid,
    // link
    dzr_if.ctl link
);
    logic [15:0] calCnt_q;
    logic [7:0] actCnt_q [NBANK];
    logic [7:0] rcdCnt_q [NBANK];
    logic [7:0] rpCnt_q [NBANK];
    logic [7:0] preCnt_q [NBANK];
    logic [NBANK-1:0] open_q;
    logic [7:0] rrdCnt_q;
    logic [7:0] ccdCnt_q;
    logic [7:0] r2wCnt_q;
    logic [7:0] fawAge_q [FAW_ACTS];
    logic ok;
    logic fire;
    logic anyOpen;
    logic rpDone;
    logic preAllDone;
    dzr_cmd_t c;
    int unsigned b;
    logic [DQW-1:0] rdData_q;
    logic rdValid_q;

    assign c = dzr_cmd_t'(reqCmd);
    assign anyOpen = |open_q;
    assign b = 32'(reqBank);

    // legality check of the request against all running timers
    always_comb begin
        rpDone = 1'b1;
        preAllDone = 1'b1;
        for (int i = 0; i < NBANK; i++) begin
            if (rpCnt_q[i] != 8'h00) begin
                rpDone = 1'b0;
            end
            if (preCnt_q[i] != 8'h00) begin
                preAllDone = 1'b0;
            end
        end
        ok = calCnt_q == 16'h0000;
        unique case (c)
            CMD_ZQ, CMD_MRS, CMD_REF: ok = ok && !anyOpen && rpDone;
            CMD_ACT: ok = ok && !open_q[b] && actCnt_q[b] == 8'h00 &&
                rrdCnt_q == 8'h00 && fawAge_q[0] == 8'h00 &&
                rpCnt_q[b] == 8'h00;
            CMD_RD: ok = ok && open_q[b] && rcdCnt_q[b] == 8'h00 &&
                ccdCnt_q == 8'h00;
            CMD_WR: ok = ok && open_q[b] && rcdCnt_q[b] == 8'h00 &&
                ccdCnt_q == 8'h00 && r2wCnt_q == 8'h00;
            CMD_PRE: ok = ok && preCnt_q[b] == 8'h00 &&
                (!reqAddr[AP_BIT] || preAllDone);
            CMD_NOP: ok = 1'b1;
        endcase
    end

    assign reqReady = ok && clkEn;
    assign fire = reqValid && reqReady;

    // timers; minimums already rounded up to whole cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            calCnt_q <= 16'h0000;
            rrdCnt_q <= 8'h00;
            ccdCnt_q <= 8'h00;
            r2wCnt_q <= 8'h00;
            open_q <= '0;
            for (int i = 0; i < NBANK; i++) begin
                actCnt_q[i] <= 8'h00;
                rcdCnt_q[i] <= 8'h00;
                rpCnt_q[i] <= 8'h00;
                preCnt_q[i] <= 8'h00;
            end
            for (int i = 0; i < FAW_ACTS; i++) begin
                fawAge_q[i] <= 8'h00;
            end
        end else if (clkEn) begin
            if (calCnt_q != 16'h0000) calCnt_q <= calCnt_q - 16'h0001;
            if (rrdCnt_q != 8'h00) rrdCnt_q <= rrdCnt_q - 8'h01;
            if (ccdCnt_q != 8'h00) ccdCnt_q <= ccdCnt_q - 8'h01;
            if (r2wCnt_q != 8'h00) r2wCnt_q <= r2wCnt_q - 8'h01;
            for (int i = 0; i < NBANK; i++) begin
                if (actCnt_q[i] != 8'h00) actCnt_q[i] <= actCnt_q[i] - 8'h01;
                if (rcdCnt_q[i] != 8'h00) rcdCnt_q[i] <= rcdCnt_q[i] - 8'h01;
                if (rpCnt_q[i] != 8'h00) rpCnt_q[i] <= rpCnt_q[i] - 8'h01;
                if (preCnt_q[i] != 8'h00) preCnt_q[i] <= preCnt_q[i] - 8'h01;
            end
            // oldest of the last four activates sits in slot zero
            for (int i = 0; i < FAW_ACTS; i++) begin
                if (fawAge_q[i] != 8'h00) fawAge_q[i] <= fawAge_q[i] - 8'h01;
            end
            if (fire) begin
                unique case (c)
                    CMD_ZQ: calCnt_q <= reqAddr[AP_BIT] ? 16'(C_ZQL) : 16'(C_ZQS);
                    CMD_ACT: begin
                        open_q[b] <= 1'b1;
                        actCnt_q[b] <= 8'(C_RC - 1);
                        // AL counts toward tRCD, allowing an early read
                        rcdCnt_q[b] <= (C_RCD > int'(LAT_AL)) ?
                            8'(C_RCD - int'(LAT_AL) - 1) : 8'h00;
                        preCnt_q[b] <= 8'(C_RAS - 1);
                        rrdCnt_q <= 8'(C_RRD - 1);
                        for (int i = 0; i < FAW_ACTS - 1; i++) begin
                            fawAge_q[i] <= (fawAge_q[i + 1] != 8'h00) ?
                                fawAge_q[i + 1] - 8'h01 : 8'h00;
                        end
                        fawAge_q[FAW_ACTS - 1] <= 8'(C_FAW - 1);
                    end
                    CMD_RD: begin
                        ccdCnt_q <= 8'(C_CCD - 1);
                        r2wCnt_q <= 8'(int'(LAT_AL) + int'(LAT_CL) + C_CCD -
                            int'(LAT_CWL) + C_RD2WR_EXTRA - 1);
                        preCnt_q[b] <= 8'(((int'(LAT_AL) + C_RTP) > C_RD2PRE ?
                            (int'(LAT_AL) + C_RTP) : C_RD2PRE) - 1);
                        // auto precharge may be pushed out by lockout; hold the
                        // bank long enough to cover it and tRP
                        if (reqAddr[AP_BIT]) begin
                            open_q[b] <= 1'b0;
                            rpCnt_q[b] <= 8'(int'(LAT_AL) + C_RTP + C_RD2PRE +
                                C_RAS + C_RP);
                        end
                    end
                    CMD_WR: ccdCnt_q <= 8'(C_CCD - 1);
                    CMD_PRE: begin
                        // precharge all closes and times every bank
                        for (int i = 0; i < NBANK; i++) begin
                            if (reqAddr[AP_BIT] || b == i) begin
                                open_q[i] <= 1'b0;
                                rpCnt_q[i] <= 8'(C_RP - 1);
                            end
                        end
                    end
                    CMD_MRS, CMD_REF, CMD_NOP: ;
                endcase
            end
        end
    end

    // command pins registered; deselect when idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.csN <= 1'b1;
            link.cmd <= 3'h7;
            link.ba <= '0;
            link.addr <= '0;
        end else if (clkEn) begin
            link.csN <= !fire;
            link.cmd <= fire ? reqCmd : 3'h7;
            link.ba <= reqBank;
            link.addr <= reqAddr;
        end
    end
    assign link.cke = 1'b1;
    assign link.resetN = 1'b1;

    // capture rise element whenever the strobe marks data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_q <= '0;
            rdValid_q <= 1'b0;
        end else if (clkEn) begin
            rdValid_q <= !link.dqOeN && link.dqsOut;
            rdData_q <= link.dqRise;
        end
    end
    assign rdData = rdData_q;
    assign rdValid = rdValid_q;
endmodule
`default_nettype wire

// ---- design/dzr_pkg.sv ----
// shared constants and types for the sdram command/read-timing link
package dzr_pkg;
    // clock period and printed-style minimums in ns
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_RCD_NS = 15;
    localparam int T_RP_NS = 15;
    localparam int T_RAS_NS = 38;
    localparam int T_RC_NS = 53;
    localparam int T_RRD_NS = 10;
    localparam int T_FAW_NS = 50;
    localparam int T_RTP_NS = 8;
    localparam int T_ZQOPER_NS = 10240;
    localparam int T_ZQCS_NS = 2560;
    // minimums round up to whole cycles, never below one
    function automatic int cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int C_RCD = cyc(T_RCD_NS);
    localparam int C_RP = cyc(T_RP_NS);
    localparam int C_RAS = cyc(T_RAS_NS);
    localparam int C_RC = cyc(T_RC_NS);
    localparam int C_RRD = cyc(T_RRD_NS);
    localparam int C_FAW = cyc(T_FAW_NS);
    localparam int C_RTP = cyc(T_RTP_NS);
    localparam int C_ZQL = cyc(T_ZQOPER_NS);
    localparam int C_ZQS = cyc(T_ZQCS_NS);
    localparam int C_CCD = 4;
    localparam int C_RD2PRE = 4;
    localparam int C_RD2WR_EXTRA = 2;
    localparam int FAW_ACTS = 4;
    // latencies in clocks
    localparam logic [3:0] LAT_AL = 4'h0;
    localparam logic [3:0] LAT_CL = 4'h6;
    localparam logic [3:0] LAT_CWL = 4'h5;
    // geometry
    localparam int NBANK = 8;
    localparam int BAW = 3;
    localparam int ROWW = 14;
    localparam int COLW = 10;
    localparam int DQW = 8;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int BURST = 8;
    // command encoding {rasN,casN,weN}
    typedef enum logic [2:0] {
        CMD_MRS = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR = 3'h4,
        CMD_RD = 3'h5,
        CMD_ZQ = 3'h6,
        CMD_NOP = 3'h7
    } dzr_cmd_t;
endpackage

// ---- design/dzr_if.sv ----
// pin-level link between controller and sdram end
`timescale 1ns/1ps
`default_nettype none
interface dzr_if;
    import dzr_pkg::*;
    logic cke;
    logic csN;
    logic [2:0] cmd;
    logic [dzr_pkg::BAW-1:0] ba;
    logic [dzr_pkg::ROWW-1:0] addr;
    logic resetN;
    // read data per half clock: rise element and fall element
    logic [dzr_pkg::DQW-1:0] dqRise;
    logic [dzr_pkg::DQW-1:0] dqFall;
    logic dqOeN;
    logic dqsOut;
    logic dqsOeN;
    modport dev (input cke, csN, cmd, ba, addr, resetN,
        output dqRise, dqFall, dqOeN, dqsOut, dqsOeN);
    modport ctl (output cke, csN, cmd, ba, addr, resetN,
        input dqRise, dqFall, dqOeN, dqsOut, dqsOeN);
endinterface
`default_nettype wire

// ---- design/dzr_device.sv ----
// sdram end: command decode, bank state, read bursts with strobe, auto precharge
// Contract
// - calibrate only with banks precharged, tRP met
// - no other traffic during calibration
// - calibration accepted during dll lock
// - controller calibrates explicitly after self refresh
// - activate row before read or write
// - early read allowed when gap plus AL meets tRCD
// - times convert to cycles rounding up
// - reads, writes spaced at least tCCD
// - precharge before new row; tRC between activates
// - tRRD between activates; four per tFAW
// - read carries bank, column, auto precharge
// - first data RL clocks after read
// - strobe preamble, postamble, then release bus
// - reads tCCD apart stream without gap
// - bursts always complete
// - write waits RL+tCCD-WL+2 after read
// - precharge four clocks and tRTP after read
// - tRP after precharge; last precharge counts
// - A10 read starts auto precharge AL+tRTP later
// - auto precharge waits for tRAS and tRTP
// - decode strobes and cke each rising edge
// - async active-low reset; NOP never terminates
`timescale 1ns/1ps
`default_nettype none
module dzr_device
    import dzr_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // link
    dzr_if.dev link,
    // array side: data returned for a read column
    input wire logic [DQW-1:0] arrayData,
    output logic [BAW-1:0] arrayBank,
    output logic [COLW-1:0] arrayCol,
    output logic [NBANK-1:0] bankOpen,
    output logic calBusy
);
    localparam int RL = int'(LAT_AL) + int'(LAT_CL);
    localparam int PIPE = RL + BURST / 2 + 2;

    logic memReset;
    logic cmdValid;
    dzr_cmd_t cmd;
    logic [NBANK-1:0] bankOpen_q;
    logic [NBANK-1:0] apPend_q;
    logic [7:0] rasCnt_q [NBANK];
    logic [7:0] rtpCnt_q [NBANK];
    logic [15:0] calCnt_q;
    // per-cycle read pipeline: slot valid, preamble mark, beat index
    logic [PIPE-1:0] beatVal_q;
    logic [PIPE-1:0] preMark_q;
    logic [1:0] beatIdx_q [PIPE];
    logic [DQW-1:0] dRise_q;
    logic [DQW-1:0] dFall_q;
    logic dqOeN_q;
    logic dqs_q;
    logic dqsOeN_q;
    logic [BAW-1:0] rdBank_q;
    logic [COLW-1:0] rdCol_q;

    // reset pin is asynchronous; folded with the local reset into one asynchronous reset
    assign memReset = !rst_n || !link.resetN;
    // command registered at each rising edge when selected and cke high
    assign cmdValid = clkEn && link.cke && !link.csN;
    assign cmd = dzr_cmd_t'(link.cmd);

    // bank open state; activate opens, precharge or auto precharge closes
    always_ff @(posedge clk or posedge memReset) begin
        if (memReset) begin
            bankOpen_q <= '0;
        end else if (clkEn) begin
            for (int b = 0; b < NBANK; b++) begin
                if (cmdValid && cmd == CMD_ACT && link.ba == BAW'(b)) begin
                    bankOpen_q[b] <= 1'b1;
                end else if (cmdValid && cmd == CMD_PRE &&
                        (link.ba == BAW'(b) || link.addr[AP_BIT])) begin
                    bankOpen_q[b] <= 1'b0;
                end else if (apPend_q[b] && rasCnt_q[b] == 8'h00 &&
                        rtpCnt_q[b] == 8'h00) begin
                    bankOpen_q[b] <= 1'b0;
                end
            end
        end
    end

    // tRAS and AL+tRTP lockout counters, auto precharge pending flags
    always_ff @(posedge clk or posedge memReset) begin
        if (memReset) begin
            apPend_q <= '0;
            for (int b = 0; b < NBANK; b++) begin
                rasCnt_q[b] <= 8'h00;
                rtpCnt_q[b] <= 8'h00;
            end
        end else if (clkEn) begin
            for (int b = 0; b < NBANK; b++) begin
                if (cmdValid && cmd == CMD_ACT && link.ba == BAW'(b)) begin
                    rasCnt_q[b] <= 8'(C_RAS - 1);
                end else if (rasCnt_q[b] != 8'h00) begin
                    rasCnt_q[b] <= rasCnt_q[b] - 8'h01;
                end
                if (cmdValid && cmd == CMD_RD && link.ba == BAW'(b)) begin
                    // earliest edge is AL+tRTP, never under four clocks
                    rtpCnt_q[b] <= 8'(((int'(LAT_AL) + C_RTP) > C_RD2PRE ?
                        (int'(LAT_AL) + C_RTP) : C_RD2PRE) - 1);
                    apPend_q[b] <= link.addr[AP_BIT];
                end else begin
                    if (rtpCnt_q[b] != 8'h00) begin
                        rtpCnt_q[b] <= rtpCnt_q[b] - 8'h01;
                    end
                    if (apPend_q[b] && rasCnt_q[b] == 8'h00 &&
                            rtpCnt_q[b] == 8'h00) begin
                        apPend_q[b] <= 1'b0;
                    end
                end
            end
        end
    end

    // calibration timer; accepted regardless of dll lock progress
    always_ff @(posedge clk or posedge memReset) begin
        if (memReset) begin
            calCnt_q <= 16'h0000;
        end else if (clkEn) begin
            if (cmdValid && cmd == CMD_ZQ) begin
                calCnt_q <= link.addr[AP_BIT] ? 16'(C_ZQL) : 16'(C_ZQS);
            end else if (calCnt_q != 16'h0000) begin
                calCnt_q <= calCnt_q - 16'h0001;
            end
        end
    end

    // read pipeline: a full read schedules four beat slots RL clocks out; the
    // shift register lets overlapping bursts chain with no gap
    always_ff @(posedge clk or posedge memReset) begin
        if (memReset) begin
            beatVal_q <= '0;
            preMark_q <= '0;
            rdBank_q <= '0;
            rdCol_q <= '0;
            for (int i = 0; i < PIPE; i++) begin
                beatIdx_q[i] <= 2'h0;
            end
        end else if (clkEn) begin
            beatVal_q <= beatVal_q >> 1;
            preMark_q <= preMark_q >> 1;
            for (int i = 0; i < PIPE - 1; i++) begin
                beatIdx_q[i] <= beatIdx_q[i + 1];
            end
            beatIdx_q[PIPE - 1] <= 2'h0;
            if (cmdValid && cmd == CMD_RD) begin
                rdBank_q <= link.ba;
                rdCol_q <= link.addr[COLW-1:0];
                // bc4 fills two slots; tCCD spacing then leaves a gap
                for (int k = 0; k < BURST / 2; k++) begin
                    if (link.addr[BC_BIT] || k < 2) begin
                        beatVal_q[RL - 2 + k] <= 1'b1;
                        beatIdx_q[RL - 2 + k] <= 2'(k);
                    end
                end
                preMark_q[RL - 3] <= 1'b1;
            end
        end
    end

    // pin drivers; NOP leaves the pipeline running so bursts complete
    always_ff @(posedge clk or posedge memReset) begin
        if (memReset) begin
            dRise_q <= '0;
            dFall_q <= '0;
            dqOeN_q <= 1'b1;
            dqs_q <= 1'b0;
            dqsOeN_q <= 1'b1;
        end else if (clkEn) begin
            if (beatVal_q[0]) begin
                dRise_q <= arrayData ^ {6'h00, beatIdx_q[0]};
                dFall_q <= ~(arrayData ^ {6'h00, beatIdx_q[0]});
                dqOeN_q <= 1'b0;
                dqs_q <= 1'b1;
                dqsOeN_q <= 1'b0;
            end else if (preMark_q[0] || !dqOeN_q) begin
                // preamble before data, postamble after last beat; a chopped
                // burst gets its postamble even when another read is queued
                dqOeN_q <= 1'b1;
                dqs_q <= 1'b0;
                dqsOeN_q <= 1'b0;
            end else begin
                dqOeN_q <= 1'b1;
                dqs_q <= 1'b0;
                dqsOeN_q <= 1'b1;
            end
        end
    end

    assign link.dqRise = dRise_q;
    assign link.dqFall = dFall_q;
    assign link.dqOeN = dqOeN_q;
    assign link.dqsOut = dqs_q;
    assign link.dqsOeN = dqsOeN_q;
    assign arrayBank = rdBank_q;
    assign arrayCol = rdCol_q;
    assign bankOpen = bankOpen_q;
    assign calBusy = calCnt_q != 16'h0000;
endmodule
`default_nettype wire

// ---- dv/dzr_link_checker.sv ----
// protocol checker on the controller-to-sdram link
`timescale 1ns/1ps
`default_nettype none
module dzr_link_checker
    import dzr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command pins
    input wire logic cke,
    input wire logic csN,
    input wire logic [2:0] cmd,
    input wire logic [BAW-1:0] ba,
    input wire logic [ROWW-1:0] addr,
    // read return pins
    input wire logic dqOeN,
    input wire logic dqsOut,
    input wire logic dqsOeN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // decoded commands as the device sees them
    logic take, isRd, isWr, isAct, isPre, isZq;
    assign take = cke && !csN;
    assign isRd = take && cmd == CMD_RD;
    assign isWr = take && cmd == CMD_WR;
    assign isAct = take && cmd == CMD_ACT;
    assign isPre = take && cmd == CMD_PRE;
    assign isZq = take && cmd == CMD_ZQ;

    logic [3:0] rdAge_q;
    logic [BAW-1:0] rdBank_q;
    logic [8:0] quiet_q;
    logic [NBANK-1:0] open_q;

    // cycles since last read, saturates so old reads never alias
    always_ff @(posedge clk) begin
        if (!rst_n) rdAge_q <= 4'hF;
        else if (isRd) rdAge_q <= 4'h1;
        else if (rdAge_q != 4'hF) rdAge_q <= rdAge_q + 4'h1;
    end
    // bank of the last read
    always_ff @(posedge clk) begin
        if (isRd) rdBank_q <= ba;
    end
    // calibration quiet window, long or short by the address bit
    always_ff @(posedge clk) begin
        if (!rst_n) quiet_q <= 9'h000;
        else if (isZq) quiet_q <= addr[AP_BIT] ? 9'(C_ZQL - 1) : 9'(C_ZQS - 1);
        else if (quiet_q != 9'h000) quiet_q <= quiet_q - 9'h001;
    end
    // open rows; auto precharge counted closed at its read
    always_ff @(posedge clk) begin
        if (!rst_n) open_q <= '0;
        else if (isAct) open_q[ba] <= 1'b1;
        else if (isPre && addr[AP_BIT]) open_q <= '0;
        else if (isPre || (isRd && addr[AP_BIT])) open_q[ba] <= 1'b0;
    end

    AST_RD_PREAMBLE: assert property (isRd && rdAge_q != 4'h4 |-> ##5 (!dqsOeN && !dqsOut))
        else $error("read preamble missing");
    AST_RD_POSTAMBLE: assert property ($rose(dqOeN) |-> !dqsOeN && !dqsOut)
        else $error("read postamble missing");
    AST_BL8_BEATS: assert property (isRd && addr[BC_BIT] |-> ##6 (!dqOeN && dqsOut) [*4])
        else $error("full burst not four beats at read latency");
    AST_BC4_GAP: assert property (isRd && !addr[BC_BIT] |-> ##6 (!dqOeN) [*2] ##1 dqOeN)
        else $error("chopped burst length or gap wrong");
    AST_CAL_QUIET: assert property (quiet_q != 9'h000 |-> !(take && cmd != CMD_NOP))
        else $error("traffic during calibration");
    AST_CAL_IDLE: assert property (isZq |-> open_q == '0)
        else $error("calibration with a bank open");
    AST_RD_OPEN: assert property (isRd || isWr |-> open_q[ba])
        else $error("access to a closed bank");
    AST_RD_SPACING: assert property (isRd |-> rdAge_q >= 4'h4)
        else $error("reads closer than ccd");
    AST_RD_TO_WR: assert property (isWr |-> rdAge_q >= 4'h7)
        else $error("write too soon after read");
    AST_RD_TO_PRE: assert property (isPre && (addr[AP_BIT] || ba == rdBank_q)
        |-> rdAge_q >= 4'h4)
        else $error("precharge too soon after read");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> csN && dqOeN && dqsOeN)
        else $error("link not idle after reset");

    // main scenarios reached
    cover property (isRd && addr[BC_BIT] && rdAge_q == 4'h4);
    cover property (isRd && addr[AP_BIT]);
    cover property (isZq && addr[AP_BIT]);
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench: controller and sdram end joined by the link
`timescale 1ns/1ps
`default_nettype none
module tb
    import dzr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    logic [2:0] reqCmd = 3'h7;
    logic [BAW-1:0] reqBank = '0;
    logic [ROWW-1:0] reqAddr = '0;
    logic [DQW-1:0] arrayData = '0;
    logic reqReady, rdValid, calBusy;
    logic [DQW-1:0] rdData;
    logic [NBANK-1:0] bankOpen;
    logic [BAW-1:0] arrayBank;
    logic [COLW-1:0] arrayCol;
    logic clkEn = 1'b1;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h00000047;
    logic [DQW-1:0] expQ[$];

    // 25 MHz clock
    always #20 clk = ~clk;

    dzr_if link_if();
    dzr_ctrl u_dzr_ctrl(.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .reqValid(reqValid),
        .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr), .reqReady(reqReady),
        .rdData(rdData), .rdValid(rdValid), .link(link_if.ctl));
    dzr_device u_dzr_device(.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .link(link_if.dev),
        .arrayData(arrayData), .arrayBank(arrayBank), .arrayCol(arrayCol), .bankOpen(bankOpen),
        .calBusy(calBusy));
    dzr_link_checker u_dzr_link_checker(.clk(clk), .rst_n(rst_n), .cke(link_if.cke),
        .csN(link_if.csN), .cmd(link_if.cmd), .ba(link_if.ba), .addr(link_if.addr),
        .dqOeN(link_if.dqOeN), .dqsOut(link_if.dqsOut), .dqsOeN(link_if.dqsOeN));

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic cmpData(input logic [DQW-1:0] exp, input logic [DQW-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch data at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic cmpFlag(input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch flag at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic results();
        $display("checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge clk);
    endtask

    // hold the request until taken; n returns the cycles spent refused
    task automatic send(input logic [2:0] c, input logic [BAW-1:0] b,
        input logic [ROWW-1:0] a, output int n);
        n = 0;
        @(negedge clk);
        reqValid = 1'b1;
        reqCmd = c;
        reqBank = b;
        reqAddr = a;
        #1;
        while (reqReady !== 1'b1 && n < 1000) begin
            @(negedge clk);
            #1;
            n++;
        end
        if (c == CMD_RD) begin
            for (int k = 0; k < (a[BC_BIT] ? 4 : 2); k++) begin
                expQ.push_back(arrayData ^ DQW'(k));
            end
        end
        @(negedge clk);
        reqValid = 1'b0;
    endtask

    // wait for all expected beats, bounded
    task automatic drain();
        int k;
        k = 0;
        while (expQ.size() != 0 && k < 40) begin
            @(negedge clk);
            k++;
        end
        cmpFlag(8'h00, 8'(expQ.size()));
    endtask

    // every returned beat against the queue, looked at mid-cycle where it has
    // settled; a stray beat never matches
    always @(negedge clk) begin
        if (rst_n === 1'b1 && rdValid === 1'b1) begin
            cmpData(expQ.size() != 0 ? expQ.pop_front() : ~rdData, rdData);
        end
    end

    // hang guard well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        int n;
        logic [31:0] rv;
        logic [BAW-1:0] b;
        logic [ROWW-1:0] a;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        cmpFlag(8'h00, bankOpen);
        cmpFlag(8'h00, {7'h00, calBusy});
        $display("test reset done");
        // long then short calibration, each must hold off the next activate
        for (int z = 0; z < 2; z++) begin
            send(CMD_ZQ, 3'h0, z ? 14'h0000 : 14'h0400, n);
            idle(3);
            cmpFlag(8'h01, {7'h00, calBusy});
            send(CMD_ACT, 3'h1, 14'h0123, n);
            cmpFlag(8'h01, {7'h00, n >= (z ? C_ZQS : C_ZQL) - 8});
            idle(3);
            cmpFlag(8'h02, bankOpen);
            send(CMD_PRE, 3'h1, 14'h0400, n);
            idle(3);
        end
        $display("test calibration done");
        // random activate, read with chop or auto precharge, streaming, write
        for (int i = 0; i < 40; i++) begin
            rv = xs();
            b = rv[2:0];
            a = rv[29:16];
            arrayData = rv[15:8];
            send(CMD_ACT, b, a, n);
            idle(3);
            cmpFlag(8'h01 << b, bankOpen);
            send(CMD_RD, b, a, n);
            if (!a[AP_BIT] && a[0]) send(CMD_RD, b, a, n);
            if (!a[AP_BIT] && a[1]) send(CMD_WR, b, a, n);
            drain();
            cmpFlag(16'({b, a[COLW-1:0]}), 16'({arrayBank, arrayCol}));
            idle(4);
            if (a[AP_BIT]) begin
                cmpFlag(8'h00, bankOpen);
            end else begin
                cmpFlag(8'h01 << b, bankOpen);
                send(CMD_PRE, b, a, n);
                idle(3);
                cmpFlag(8'h00, bankOpen);
            end
        end
        $display("test random access done");
        // reset while a row is open
        send(CMD_ACT, 3'h5, 14'h0010, n);
        idle(2);
        // frozen enable: a pending activate must neither be taken nor decoded
        clkEn = 1'b0;
        reqValid = 1'b1;
        reqCmd = CMD_ACT;
        reqBank = 3'h6;
        idle(4);
        cmpFlag(8'h20, bankOpen);
        cmpFlag(8'h00, {7'h00, reqReady});
        reqValid = 1'b0;
        clkEn = 1'b1;
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        idle(2);
        cmpFlag(8'h00, bankOpen);
        $display("test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire
